//--- hdl/host_port_defines.svh
// Constants for the processor strobe and host FIFO port.
// Assumes inclusion by bare name from hdl/.
`ifndef HOST_PORT_DEFINES_SVH
`define HOST_PORT_DEFINES_SVH

`define HP_ADDR_W        8
`define HP_DATA_W        8
`define HP_REG_W         5
`define HP_FIFO_REG_IDX  5'h0c
`define HP_MODE_HAP_BIT  0
`define HP_MODE_FRQ_BIT  2
`define HP_ADDR_RST      8'h00
`define HP_DATA_RST      8'h00
`define HP_CHIP_SEL_VAL  3'h0
`define HP_CS_MSB        7
`define HP_CS_LSB        5

`endif

//--- hdl/host_port_pkg.sv
// Types shared by the host port.
// Assumes host_port_defines.svh is compiled alongside.
package host_port_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_WAIT = 3'b010,
		ST_DONE = 3'b100
	} acc_state_e;
endpackage

//--- hdl/mpu_strobe_host_port.sv
// Processor-side front end: strobe-mode multiplexed bus and host adapter FIFO access.
// Assumes all inputs synchronous to clk_sys_in; FIFO core sits outside this module.
`timescale 1ns/100ps
`include "host_port_defines.svh"

// Overview of operation
// R1: Strobe mode only while bus style pin high
// R2: Address strobe latches address for selection
// R3: Data strobe honoured only while qualifier low
// R4: Read when read/write high, else write
// R5: Host qualifiers force FIFO data register access
// R6: Wide indication asserted on FIFO wide access
// R7: Wide indication enabled by mode bit 0
// R8: FIFO request when FIFO needs or holds byte
// R9: FIFO request cleared on FIFO register access
// R10: FIFO request enabled by mode bit 2
// R11: Host ready enabled by mode bit 0
// R12: Ready dropped when FIFO cannot serve access
// R13: Address enable overrides address, undriven reads asserted
// R14: Acknowledge forces internal chip select
// R15: Ready returns once FIFO can serve access
// R16: Latched address held between address strobes
module mpu_strobe_host_port (
	// Clock and reset
	input  wire logic                     clk_sys_in,
	input  wire logic                     rstn_in,
	// Configuration
	input  wire logic                     bus_style_config_pin_in,
	input  wire logic [7:0]               mode_ctrl_in,
	input  wire logic                     wide_access_in,
	// Processor bus
	input  wire logic [`HP_ADDR_W-1:0]    ad_in,
	output logic      [`HP_DATA_W-1:0]    ad_out,
	output logic                          ad_oe_out,
	input  wire logic                     addr_latch_strobe_in,
	input  wire logic                     data_memory_qualifier_in,
	input  wire logic                     read_or_data_strobe_n_in,
	input  wire logic                     write_or_read_write_sel_in,
	input  wire logic                     write_strobe_n_in,
	// Host adapter qualifiers
	input  wire logic                     host_addr_enable_qual_in,
	input  wire logic                     host_ack_qual_n_in,
	// Host adapter outputs
	output logic                          wide_host_access_n_out,
	output logic                          wide_host_access_oe_out,
	output logic                          fifo_req_out,
	output logic                          fifo_req_oe_out,
	output logic                          host_ready_out,
	output logic                          host_ready_oe_out,
	// Register file side
	output logic [`HP_REG_W-1:0]          reg_sel_out,
	output logic                          reg_rd_out,
	output logic                          reg_wr_out,
	output logic [`HP_DATA_W-1:0]         reg_wdata_out,
	input  wire logic [`HP_DATA_W-1:0]    reg_rdata_in,
	// FIFO status
	input  wire logic                     fifo_has_byte_in,
	input  wire logic                     fifo_has_room_in
);

	// Access sequencer state
	host_port_pkg::acc_state_e state_r;
	host_port_pkg::acc_state_e state_nxt;
	logic [`HP_DATA_W-1:0]     rdata_r;
	logic [`HP_DATA_W-1:0]     rdata_nxt;
	logic                      frq_clr_r;
	logic                      frq_clr_nxt;

	// Address latch state
	logic [`HP_ADDR_W-1:0]     addr_r;
	logic [`HP_ADDR_W-1:0]     addr_nxt;
	logic                      as_d_r;
	logic                      as_d_nxt;

	// Registered pin flags
	logic                      oe_r;
	logic                      oe_nxt;
	logic                      wide_r;
	logic                      wide_nxt;

	// Access decode
	logic                      strobe_mode;
	logic                      host_force;
	logic                      chip_sel;
	logic                      rd_act;
	logic                      wr_act;
	logic                      fifo_acc;
	logic                      fifo_ok;
	logic [`HP_REG_W-1:0]      sel;

	// Decode of the current access
	always_comb begin
		strobe_mode = bus_style_config_pin_in; // R1
		// Qualifiers override the address; open address enable reads high at the pad
		host_force  = host_addr_enable_qual_in && !host_ack_qual_n_in && !data_memory_qualifier_in
		              && (!read_or_data_strobe_n_in || !write_strobe_n_in); // R5 R13
		chip_sel    = (addr_r[`HP_CS_MSB:`HP_CS_LSB] == `HP_CHIP_SEL_VAL) || !host_ack_qual_n_in; // R2 R14
		if (strobe_mode) begin
			// Data strobe qualified low, direction from read/write select
			rd_act = !read_or_data_strobe_n_in && !data_memory_qualifier_in && write_or_read_write_sel_in; // R3 R4
			wr_act = !read_or_data_strobe_n_in && !data_memory_qualifier_in && !write_or_read_write_sel_in; // R3 R4
		end else begin
			// Host strobes count only under the forcing qualifiers
			rd_act = host_force && !read_or_data_strobe_n_in;
			wr_act = host_force && !write_strobe_n_in;
		end
		sel      = host_force ? `HP_FIFO_REG_IDX : addr_r[`HP_REG_W-1:0]; // R5 R2
		fifo_acc = (rd_act || wr_act) && chip_sel && (sel == `HP_FIFO_REG_IDX);
		fifo_ok  = rd_act ? fifo_has_byte_in : fifo_has_room_in;
	end

	// Address latch: capture on the strobe's falling edge
	always_comb begin
		as_d_nxt = addr_latch_strobe_in;
		// Keep the last address until the next falling strobe
		addr_nxt = addr_r; // R16
		if (strobe_mode && as_d_r && !addr_latch_strobe_in) begin
			addr_nxt = ad_in; // R2
		end
	end

	// Address latch registers; strobe history resets to its idle level
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			addr_r <= `HP_ADDR_RST;
			as_d_r <= 1'b1;
		end else begin
			addr_r <= addr_nxt;
			as_d_r <= as_d_nxt;
		end
	end

	// Access sequencer: stall on the FIFO, one completion per strobe
	always_comb begin
		state_nxt   = state_r;
		rdata_nxt   = rdata_r;
		// Clear flag lapses once the FIFO neither holds nor wants data
		frq_clr_nxt = frq_clr_r && (fifo_has_byte_in || fifo_has_room_in);
		unique case (state_r)
			host_port_pkg::ST_IDLE: begin
				// New access: complete now or stall the host
				if ((rd_act || wr_act) && chip_sel) begin
					if (fifo_acc && !fifo_ok) begin
						state_nxt = host_port_pkg::ST_WAIT; // R12
					end else begin
						state_nxt = host_port_pkg::ST_DONE;
						rdata_nxt = reg_rdata_in;
						if (fifo_acc) begin
							frq_clr_nxt = 1'b1; // R9
						end
					end
				end
			end
			host_port_pkg::ST_WAIT: begin
				// Stalled: finish when the FIFO can serve, drop if the strobe goes
				if (!(rd_act || wr_act)) begin
					state_nxt = host_port_pkg::ST_IDLE;
				end else if (fifo_ok) begin
					state_nxt   = host_port_pkg::ST_DONE; // R15
					rdata_nxt   = reg_rdata_in;
					frq_clr_nxt = 1'b1; // R9
				end
			end
			host_port_pkg::ST_DONE: begin
				// Completed: hold until the strobe returns inactive
				if (!(rd_act || wr_act)) begin
					state_nxt = host_port_pkg::ST_IDLE;
				end
			end
		endcase
	end

	// Access sequencer registers
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state_r   <= host_port_pkg::ST_IDLE;
			rdata_r   <= `HP_DATA_RST;
			frq_clr_r <= 1'b0;
		end else begin
			state_r   <= state_nxt;
			rdata_r   <= rdata_nxt;
			frq_clr_r <= frq_clr_nxt;
		end
	end

	// Pin flags: read drive enable and wide access marker
	always_comb begin
		oe_nxt   = rd_act && chip_sel; // R4
		wide_nxt = fifo_acc && wide_access_in; // R6
	end

	// Pin flag registers
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			oe_r   <= 1'b0;
			wide_r <= 1'b0;
		end else begin
			oe_r   <= oe_nxt;
			wide_r <= wide_nxt;
		end
	end

	// Register file strobes, one pulse per completed access
	assign reg_sel_out   = sel;
	assign reg_rd_out    = rd_act && (state_nxt == host_port_pkg::ST_DONE) && (state_r != host_port_pkg::ST_DONE);
	assign reg_wr_out    = wr_act && (state_nxt == host_port_pkg::ST_DONE) && (state_r != host_port_pkg::ST_DONE);
	assign reg_wdata_out = ad_in;

	// Read data back onto the multiplexed bus
	assign ad_out        = rdata_r;
	assign ad_oe_out     = oe_r; // R4

	// Open-drain wide indication: pin sinks while its enable is high
	assign wide_host_access_n_out  = 1'b0;
	assign wide_host_access_oe_out = wide_r && mode_ctrl_in[`HP_MODE_HAP_BIT]; // R6 R7

	// Tri-state FIFO request
	assign fifo_req_out            = (fifo_has_byte_in || fifo_has_room_in) && !frq_clr_r; // R8 R9
	assign fifo_req_oe_out         = mode_ctrl_in[`HP_MODE_FRQ_BIT]; // R10

	// Open-drain ready: sinking the pin stretches the host cycle
	assign host_ready_out          = 1'b0;
	assign host_ready_oe_out       = mode_ctrl_in[`HP_MODE_HAP_BIT] && (state_nxt == host_port_pkg::ST_WAIT); // R11 R12 R15

endmodule

//--- tb/mpu_strobe_host_port_asserts.sv
// Checker for the host port handshake outputs.
// Assumes binding into mpu_strobe_host_port.
`timescale 1ns/100ps
module mpu_strobe_host_port_asserts (
	input	wire logic		clk_sys_in,
	input	wire logic		rstn_in,
	input	wire logic		bus_style_config_pin_in,
	input	wire logic [7:0]	mode_ctrl_in,
	input	wire logic		wide_access_in,
	input	wire logic		data_memory_qualifier_in,
	input	wire logic		write_or_read_write_sel_in,
	input	logic [4:0]		reg_sel_out,
	input	logic			reg_rd_out,
	input	logic			reg_wr_out,
	input	logic			wide_host_access_oe_out,
	input	logic			fifo_req_oe_out,
	input	logic			host_ready_oe_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!rstn_in);
	// Any completed access
	wire acc = reg_rd_out | reg_wr_out;
	a_frq_oe_bit: assert property (fifo_req_oe_out == mode_ctrl_in[2]) else $error("request enable wrong");
	a_rdy_needs_hap: assert property (host_ready_oe_out |-> mode_ctrl_in[0]) else $error("ready enable wrong");
	a_ds_ignored: assert property (data_memory_qualifier_in |-> !acc) else $error("strobe not ignored");
	a_host_fifo_sel: assert property (!bus_style_config_pin_in && acc |-> reg_sel_out == 5'h0c)
		else $error("host access not forced");
	a_rw_dir: assert property (bus_style_config_pin_in && acc |-> reg_rd_out == write_or_read_write_sel_in)
		else $error("direction wrong");
	a_stall_no_pulse: assert property (host_ready_oe_out |-> !acc) else $error("access during stall");
	a_ready_return: assert property ($fell(host_ready_oe_out) && !bus_style_config_pin_in |-> acc)
		else $error("stall ended without access");
	a_wide_flag: assert property (!bus_style_config_pin_in && mode_ctrl_in[0] && wide_access_in && acc
		|=> wide_host_access_oe_out) else $error("wide flag missing");
endmodule
bind mpu_strobe_host_port mpu_strobe_host_port_asserts chk_u (.clk_sys_in, .rstn_in, .bus_style_config_pin_in,
	.mode_ctrl_in, .wide_access_in, .data_memory_qualifier_in, .write_or_read_write_sel_in, .reg_sel_out,
	.reg_rd_out, .reg_wr_out, .wide_host_access_oe_out, .fifo_req_oe_out, .host_ready_oe_out);

//--- tb/host_wait_gen.sv
// Host wait-state generator fed by the open-drain ready pin.
// Assumes an off-chip pull-up on that pin.
`timescale 1ns/100ps
module host_wait_gen (
	input	wire logic		clk_sys_in,
	input	wire logic		ready_oe_in,
	output	logic [7:0]		wait_cnt_out
);
	// Pin is low only while sunk; count stretched cycles
	always_ff @(posedge clk_sys_in) wait_cnt_out <= ready_oe_in ? wait_cnt_out + 8'h01 : 8'h00;
endmodule

//--- tb/mpu_strobe_host_port_tb_top.sv
// Random and corner tests of the strobe and host FIFO port.
// Assumes the design, checker and wait generator are compiled.
`timescale 1ns/100ps
module mpu_strobe_host_port_tb_top;
	logic		clk = 0, rst_n = 0, style = 1, wide = 0, alat = 1, dmq = 0, ds_n = 1, rw = 1, wr_n = 1, ack_n = 1;
	logic		hb = 1, hr = 1, rd, wr, wh_oe, rdy_oe, frq, frq_oe;
	logic [7:0]	mode = 8'h05, ad = 8'h00, rdat = 8'h00, q, wd, wcnt, la = 8'h00;
	logic [4:0]	sel;
	int		n_errors = 0, n_tests = 0, cyc = 0;
	always #2 clk = !clk;
	mpu_strobe_host_port dut_u (.clk_sys_in(clk), .rstn_in(rst_n), .bus_style_config_pin_in(style),
		.mode_ctrl_in(mode), .wide_access_in(wide), .ad_in(ad), .ad_out(q), .ad_oe_out(),
		.addr_latch_strobe_in(alat), .data_memory_qualifier_in(dmq), .read_or_data_strobe_n_in(ds_n),
		.write_or_read_write_sel_in(rw), .write_strobe_n_in(wr_n), .host_addr_enable_qual_in(1'b1),
		.host_ack_qual_n_in(ack_n), .wide_host_access_n_out(), .wide_host_access_oe_out(wh_oe), .fifo_req_out(frq),
		.fifo_req_oe_out(frq_oe), .host_ready_out(), .host_ready_oe_out(rdy_oe), .reg_sel_out(sel), .reg_rd_out(rd),
		.reg_wr_out(wr), .reg_wdata_out(wd), .reg_rdata_in(rdat), .fifo_has_byte_in(hb), .fifo_has_room_in(hr));
	host_wait_gen wg_u (.clk_sys_in(clk), .ready_oe_in(rdy_oe), .wait_cnt_out(wcnt));
	// Hang guard
	always @(posedge clk) if (++cyc == 3000) begin
		n_errors++;
		end_of_test();
	end
	task chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// Strobe mode: latch address, then one data strobe
	task strobe_acc(input logic [7:0] a, input logic r, input logic [7:0] d);
		la = a;
		@(posedge clk) begin ad <= a; alat <= 0; end
		@(posedge clk) alat <= 1;
		@(posedge clk) begin ad <= d; rw <= r; ds_n <= 0; rdat <= d; end
		@(negedge clk) chk("sel", {3'h0, sel}, {3'h0, a[4:0]});
		chk("pulse", {6'h0, rd, wr}, {6'h0, r, !r});
		if (!r) chk("wdata", wd, d);
		@(posedge clk) ds_n <= 1;
		@(negedge clk) if (r) chk("rdata", q, d);
	endtask
	// Host access stalled until the FIFO can serve it
	task host_acc(input logic r, input logic w, input int st);
		@(posedge clk) begin style <= 0; ack_n <= 0; hb <= 0; hr <= 0; wide <= w; ds_n <= !r; wr_n <= r;
			mode <= 8'h01 | (8'($urandom) & 8'h04); end
		repeat (st) @(posedge clk);
		@(negedge clk) chk("wait count", wcnt, 8'(st));
		@(posedge clk) begin hb <= 1; hr <= 1; end
		@(negedge clk) chk("host pulse", {rdy_oe, sel, rd, wr}, {1'b0, 5'h0c, r, !r});
		chk("request", {6'h0, frq, frq_oe}, {6'h0, 1'b1, mode[2]});
		@(posedge clk) begin ds_n <= 1; wr_n <= 1; ack_n <= 1; end
		@(negedge clk) chk("wide", {7'h0, wh_oe}, {7'h0, w});
		chk("request cleared", {7'h0, frq}, 8'h00);
	endtask
	task end_of_test;
		if (n_errors == 0 && n_tests > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	initial begin
		void'($urandom(81));
		repeat (2) @(posedge clk);
		rst_n <= 1;
		strobe_acc(8'h1f, 0, 8'hff);
		repeat (20) strobe_acc({3'h0, 5'($urandom)}, 1'($urandom), 8'($urandom));
		// Data strobe with no new address strobe reuses the latched address
		@(posedge clk) begin rw <= 1; ds_n <= 0; end
		@(negedge clk) chk("held sel", {3'h0, sel}, {3'h0, la[4:0]});
		@(posedge clk) ds_n <= 1;
		// Data strobe while qualifier high
		@(posedge clk) begin dmq <= 1; ds_n <= 0; end
		@(negedge clk) chk("ignored", {6'h0, rd, wr}, 8'h00);
		@(posedge clk) ds_n <= 1;
		@(posedge clk) dmq <= 0;
		repeat (12) host_acc(1'($urandom), 1'($urandom), 1 + $urandom_range(7));
		// Host mode without the acknowledge qualifier: strobe ignored
		@(posedge clk) ds_n <= 0;
		@(negedge clk) chk("unqualified", {6'h0, rd, wr}, 8'h00);
		@(posedge clk) ds_n <= 1;
		end_of_test();
	end
endmodule
